// [verilog/epp_cycle_pkg.sv]
// Constants shared by the enhanced parallel port cycle engine.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.

package epp_cycle_pkg;

   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_DATA = 4'h0;
   localparam logic [3:0] IDX_STATUS = 4'h1;
   localparam logic [3:0] IDX_CONTROL = 4'h2;
   localparam logic [3:0] IDX_EPP_ADDR = 4'h3;
   localparam logic [3:0] IDX_EPP_DATA_FIRST = 4'h4;
   localparam logic [3:0] IDX_EPP_DATA_LAST = 4'h7;
   localparam logic [3:0] IDX_MODE = 4'h8;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STAT_TMOUT = 0;
   localparam int CTRL_STROBE = 0;
   localparam int CTRL_AUTOFD = 1;
   localparam int CTRL_INIT = 2;
   localparam int CTRL_SLCTIN = 3;
   localparam int CTRL_IRQE = 4;
   localparam int CTRL_PCD = 5;

   // ----------------------------------------------------------------
   // Port modes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_SPP = 2'h0;
   localparam logic [1:0] MODE_BIDIR = 2'h1;
   localparam logic [1:0] MODE_EPP19 = 2'h2;
   localparam logic [1:0] MODE_EPP17 = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [7:0] EPP_REG_RESET = 8'h00;
   localparam logic [7:0] ABORT_READ_BYTE = 8'hFF;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TIMEOUT_NS = 10000;
   localparam int TIMEOUT_CYCLES = (TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [11:0] TIMEOUT_LAST = 12'(TIMEOUT_CYCLES - 1);

endpackage

// [verilog/epp_input_sync.sv]
// Two-stage synchroniser for the parallel port input pins.
// Assumes the pins change with no relation to pclk.

`timescale 1ns/1ps

module epp_input_sync #(
   parameter int WIDTH = 13
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   // Stage one feeds stage two only; nothing else reads it
   always_comb begin
      next_state = state;
      next_state.stage1 = async_in;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.stage2;

endmodule

// [verilog/epp_cycle_engine.sv]
// Enhanced parallel port cycle engine with APB register access.
// Turns APB accesses at the enhanced address and data ports into
// interlocked byte handshakes, stalling pready until they finish.
// Assumes the bench resolves the byte bus from its output enable.

`timescale 1ns/1ps

module epp_cycle_engine (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port_byte_bus_in,
   output logic [7:0] port_byte_bus_out,
   output logic port_byte_bus_oe,
   output logic transfer_direction_n,
   output logic data_phase_strobe_n,
   output logic address_phase_strobe_n,
   output logic init_n,
   input wire logic peripheral_hold_n,
   input wire logic peripheral_interrupt,
   input wire logic error_n,
   input wire logic select,
   input wire logic paper_end,
   output logic parallel_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_LOW,
      ST_SETUP,
      ST_STROBE,
      ST_FINISH
   } phase_type;

   typedef struct packed {
      phase_type phase;
      logic [7:0] data_reg;
      logic [5:0] ctrl;
      logic [1:0] mode;
      logic tmout;
      logic [7:0] epp_addr;
      logic [7:0] epp_data;
      logic cycle_addr;
      logic cycle_write;
      logic cycle_drive;
      logic [11:0] count;
      logic [7:0] cycle_byte;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] bus_out;
      logic bus_oe;
      logic dir_n;
      logic dstb_n;
      logic astb_n;
      logic init_n;
      logic irq;
   } engine_state_type;

   engine_state_type state;
   engine_state_type next_state;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] pins_sync;
   logic [7:0] bus_sync;
   logic hold_sync;
   logic intr_sync;
   logic error_sync;
   logic select_sync;
   logic paper_sync;

   epp_input_sync #(
      .WIDTH(13)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({paper_end, select, error_n, peripheral_interrupt,
                 peripheral_hold_n, port_byte_bus_in}),
      .sync_out(pins_sync)
   );

   assign bus_sync = pins_sync[7:0];
   assign hold_sync = pins_sync[8];
   assign intr_sync = pins_sync[9];
   assign error_sync = pins_sync[10];
   assign select_sync = pins_sync[11];
   assign paper_sync = pins_sync[12];

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic access;
      logic done_write;
      logic [3:0] idx;
      logic aligned;
      logic epp_mode;
      logic epp_port;
      logic port_direction_bit;
      logic strobe_bit;
      logic tmout_set;
      logic tmout_clear;
      logic expired;
      logic [7:0] read_byte;
      logic unmapped;

      next_state = state;
      access = psel & penable & ~state.pready;
      done_write = psel & penable & state.pready & pwrite;
      idx = paddr[5:2];
      aligned = (paddr[1:0] == 2'h0);
      epp_mode = (state.mode == epp_cycle_pkg::MODE_EPP19) |
                 (state.mode == epp_cycle_pkg::MODE_EPP17);
      epp_port = aligned & (idx >= epp_cycle_pkg::IDX_EPP_ADDR) &
                 (idx <= epp_cycle_pkg::IDX_EPP_DATA_LAST);
      port_direction_bit = state.ctrl[epp_cycle_pkg::CTRL_PCD];
      strobe_bit = state.ctrl[epp_cycle_pkg::CTRL_STROBE];
      tmout_set = 1'b0;
      tmout_clear = 1'b0;
      expired = (state.count == epp_cycle_pkg::TIMEOUT_LAST);
      read_byte = 8'h00;
      unmapped = 1'b0;
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;

      // Read value of the plain registers
      if (!aligned) begin
         unmapped = 1'b1;
      end else begin
         case (idx)
            epp_cycle_pkg::IDX_DATA: begin
               if (state.mode != epp_cycle_pkg::MODE_SPP && port_direction_bit) begin
                  read_byte = bus_sync;
               end else begin
                  read_byte = state.data_reg;
               end
            end
            epp_cycle_pkg::IDX_STATUS: begin
               read_byte = {~hold_sync, intr_sync, paper_sync, select_sync,
                            error_sync, 2'h0, state.tmout};
            end
            epp_cycle_pkg::IDX_CONTROL: begin
               read_byte = {2'h0, state.ctrl};
            end
            epp_cycle_pkg::IDX_EPP_ADDR: begin
               read_byte = state.epp_addr;
            end
            epp_cycle_pkg::IDX_MODE: begin
               read_byte = {6'h00, state.mode};
            end
            default: begin
               if (epp_port) begin
                  read_byte = state.epp_data;
               end else begin
                  unmapped = 1'b1;
               end
            end
         endcase
      end

      // Plain register writes take effect at the completing edge
      if (done_write && aligned) begin
         case (idx)
            epp_cycle_pkg::IDX_DATA: begin
               next_state.data_reg = pwdata[7:0];
            end
            epp_cycle_pkg::IDX_STATUS: begin
               tmout_clear = pwdata[epp_cycle_pkg::STAT_TMOUT];
            end
            epp_cycle_pkg::IDX_CONTROL: begin
               next_state.ctrl = pwdata[5:0];
            end
            epp_cycle_pkg::IDX_MODE: begin
               next_state.mode = pwdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Cycle sequencer
      // ----------------------------------------------------------------
      case (state.phase)
         ST_IDLE: begin
            if (access && epp_mode && epp_port) begin
               next_state.cycle_addr = (idx == epp_cycle_pkg::IDX_EPP_ADDR);
               next_state.cycle_write = pwrite;
               next_state.cycle_byte = pwdata[7:0];
               // Timeout window opens at the taking edge
               next_state.count = 12'h000;
               if (state.mode == epp_cycle_pkg::MODE_EPP19) begin
                  // Set direction bit cannot drive: write degrades to a read
                  next_state.cycle_drive = pwrite & ~port_direction_bit;
                  if (hold_sync) begin
                     next_state.phase = ST_WAIT_LOW;
                  end else begin
                     next_state.phase = ST_SETUP;
                  end
               end else begin
                  next_state.cycle_drive = ~port_direction_bit;
                  next_state.phase = ST_STROBE;
               end
            end else if (access) begin
               next_state.pready = 1'b1;
               next_state.pslverr = unmapped;
               next_state.prdata = {24'h000000, read_byte};
            end
         end
         ST_WAIT_LOW: begin
            next_state.count = state.count + 12'h001;
            if (expired) begin
               tmout_set = 1'b1;
               // Aborted before any strobe; a read still answers all ones
               if (!state.cycle_write) begin
                  next_state.cycle_byte = epp_cycle_pkg::ABORT_READ_BYTE;
               end
               next_state.phase = ST_FINISH;
            end else if (!hold_sync) begin
               next_state.phase = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Bus and direction settle one cycle ahead of the strobe
            next_state.count = state.count + 12'h001;
            next_state.phase = ST_STROBE;
         end
         ST_STROBE: begin
            next_state.count = state.count + 12'h001;
            if (expired) begin
               tmout_set = 1'b1;
               if (!state.cycle_write) begin
                  next_state.cycle_byte = epp_cycle_pkg::ABORT_READ_BYTE;
               end
               next_state.phase = ST_FINISH;
            end else if (hold_sync) begin
               // Host stays stalled until the peripheral releases hold
               if (!state.cycle_write) begin
                  next_state.cycle_byte = bus_sync;
               end
               next_state.phase = ST_FINISH;
            end
         end
         ST_FINISH: begin
            // Strobe already dropped; now release the host
            next_state.pready = 1'b1;
            next_state.prdata = {24'h000000, state.cycle_byte};
            // Aborted writes still store the host byte
            if (state.cycle_write && state.cycle_addr) begin
               next_state.epp_addr = state.cycle_byte;
            end else if (state.cycle_write) begin
               next_state.epp_data = state.cycle_byte;
            end
            next_state.phase = ST_IDLE;
         end
         default: begin
            next_state.phase = ST_IDLE;
         end
      endcase

      // A timeout in the clearing cycle still sticks
      next_state.tmout = (state.tmout & ~tmout_clear) | tmout_set;

      // ----------------------------------------------------------------
      // Pin outputs, registered from the next phase
      // ----------------------------------------------------------------
      next_state.init_n = next_state.ctrl[epp_cycle_pkg::CTRL_INIT];
      // Pins keep their idle levels while waiting for hold to fall
      if (next_state.phase == ST_IDLE) begin
         next_state.bus_out = next_state.data_reg;
         next_state.bus_oe = (next_state.mode == epp_cycle_pkg::MODE_SPP) |
                             ~next_state.ctrl[epp_cycle_pkg::CTRL_PCD];
         next_state.dir_n = ~next_state.ctrl[epp_cycle_pkg::CTRL_STROBE];
         next_state.dstb_n = ~next_state.ctrl[epp_cycle_pkg::CTRL_AUTOFD];
         next_state.astb_n = ~next_state.ctrl[epp_cycle_pkg::CTRL_SLCTIN];
      end else if (next_state.phase != ST_WAIT_LOW) begin
         // Only direction and bus enable may be overridden by the control port strobe bit
         next_state.bus_out = next_state.cycle_byte;
         next_state.bus_oe = next_state.cycle_drive | strobe_bit;
         next_state.dir_n = ~(next_state.cycle_drive | strobe_bit);
         next_state.dstb_n = ~((next_state.phase == ST_STROBE) &
                               ~next_state.cycle_addr);
         next_state.astb_n = ~((next_state.phase == ST_STROBE) &
                               next_state.cycle_addr);
      end

      // Interrupt passes through at its own polarity
      next_state.irq = state.ctrl[epp_cycle_pkg::CTRL_IRQE] & intr_sync;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Pins rest as in standard mode with the control port clear
         state <= '0;
         state.phase <= ST_IDLE;
         state.data_reg <= epp_cycle_pkg::DATA_RESET;
         state.ctrl <= epp_cycle_pkg::CTRL_RESET;
         state.mode <= epp_cycle_pkg::MODE_RESET;
         state.epp_addr <= epp_cycle_pkg::EPP_REG_RESET;
         state.epp_data <= epp_cycle_pkg::EPP_REG_RESET;
         state.bus_oe <= 1'b1;
         state.dir_n <= 1'b1;
         state.dstb_n <= 1'b1;
         state.astb_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign port_byte_bus_out = state.bus_out;
   assign port_byte_bus_oe = state.bus_oe;
   assign transfer_direction_n = state.dir_n;
   assign data_phase_strobe_n = state.dstb_n;
   assign address_phase_strobe_n = state.astb_n;
   assign init_n = state.init_n;
   assign parallel_irq = state.irq;

endmodule

// [testbench/epp_cycle_engine_checker.sv]
// Concurrent checks on the parallel port cycle engine ports.
// Assumes software keeps control bits 1 and 3 clear around enhanced cycles.
`timescale 1ns/1ps
module epp_cycle_engine_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic port_byte_bus_oe,
   input wire logic transfer_direction_n,
   input wire logic data_phase_strobe_n,
   input wire logic address_phase_strobe_n,
   input wire logic init_n,
   input wire logic peripheral_interrupt,
   input wire logic parallel_irq
);
   localparam int WAIT_MAX = epp_cycle_pkg::TIMEOUT_CYCLES + 8;
   logic [12:0] wait_cnt;
   wire logic epp_port = paddr[5:2] >= 4'h3 && paddr[5:2] <= 4'h7 && paddr[1:0] == 2'h0;
   wire logic strobes_n = data_phase_strobe_n && address_phase_strobe_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------
   // Stall length, cut short by the watchdog
   // ------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 13'h0000;
      end else if (psel && penable && !pready) begin
         wait_cnt <= wait_cnt + 13'h0001;
      end else begin
         wait_cnt <= 13'h0000;
      end
   end
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_strobe_end;
      $rose(data_phase_strobe_n) && penable;
   endsequence
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_ready_cause;
      pready |-> $past(psel && penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
   property p_epp_no_err;
      pready && epp_port |-> !pslverr && strobes_n;
   endproperty
   a_epp_no_err: assert property (p_epp_no_err) else $error("enhanced port answer wrong");
   property p_watchdog;
      wait_cnt < 13'(WAIT_MAX);
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("stall beyond timeout");
   property p_strobe_ready;
      s_strobe_end |-> ##[0:1] pready;
   endproperty
   a_strobe_ready: assert property (p_strobe_ready) else $error("no answer after strobe");
   property p_write_drive;
      $fell(strobes_n) && !transfer_direction_n |-> port_byte_bus_oe;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write strobe with bus off");
   property p_read_float;
      $fell(strobes_n) && transfer_direction_n |-> !port_byte_bus_oe;
   endproperty
   a_read_float: assert property (p_read_float) else $error("read strobe with bus on");
   property p_init_stable;
      s_access |=> $stable(init_n);
   endproperty
   a_init_stable: assert property (p_init_stable) else $error("init moved in cycle");
   property p_irq_follow;
      !peripheral_interrupt [*5] |-> !parallel_irq;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq without input");
endmodule
bind epp_cycle_engine epp_cycle_engine_checker chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .port_byte_bus_oe(port_byte_bus_oe), .transfer_direction_n(transfer_direction_n),
   .data_phase_strobe_n(data_phase_strobe_n), .address_phase_strobe_n(address_phase_strobe_n),
   .init_n(init_n), .peripheral_interrupt(peripheral_interrupt), .parallel_irq(parallel_irq));

// [testbench/epp_peripheral_model.sv]
// Behavioural peripheral at the far end of the printer cable.
// Assumes the bench resolves the byte bus and feeds the level back.
`timescale 1ns/1ps
module epp_peripheral_model (
   input wire logic pclk,
   input wire logic data_phase_strobe_n,
   input wire logic address_phase_strobe_n,
   input wire logic transfer_direction_n,
   input wire logic [7:0] bus_level,
   input wire logic [4:0] delay,
   input wire logic stall,
   input wire logic idle_high,
   input wire logic [7:0] read_byte,
   output logic peripheral_hold_n,
   output logic drive_oe,
   output logic [7:0] drive_byte,
   output logic [7:0] got_byte,
   output logic got_dir_n,
   output logic got_addr
);
   logic [5:0] cnt;
   initial begin
      cnt = 6'h00;
      peripheral_hold_n = 1'b0;
      drive_oe = 1'b0;
   end
   always @(posedge pclk) begin
      if (data_phase_strobe_n && address_phase_strobe_n) begin
         cnt <= 6'h00;
         drive_oe <= 1'b0;
         peripheral_hold_n <= idle_high;
      end else begin
         cnt <= cnt + 6'h01;
         if (cnt == 6'h00) begin
            got_dir_n <= transfer_direction_n;
            got_addr <= !address_phase_strobe_n;
         end
         if (cnt == {1'b0, delay}) begin
            drive_oe <= transfer_direction_n;
            drive_byte <= read_byte;
            got_byte <= bus_level;
         end
         // Stall keeps hold low so the engine must time out
         if (cnt == {1'b0, delay} + 6'h01 && !stall) begin
            peripheral_hold_n <= 1'b1;
         end
      end
   end
endmodule

// [testbench/epp_cycle_engine_tb.sv]
// Self-checking bench for the parallel port cycle engine.
// Assumes the checker is bound in and the peripheral model is compiled.
`timescale 1ns/1ps
module epp_cycle_engine_tb;
   logic pclk, presetn, psel, penable, pwrite, irq_in, stall, idle_high;
   logic [5:0] paddr, a;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, bus_oe, dir_n, ds_n, as_n, init_n, hold_n, irq;
   logic m_oe, dir_got, addr_got, err;
   logic [7:0] bus_out, m_byte, got, rbyte, d;
   logic [7:0] last = 8'h00;
   logic [4:0] delay;
   int seed = 88;
   int miscompares = 0;
   int comparisons = 0;
   // Undriven bus shows a changing pattern, not a held value
   wire logic [7:0] bus = bus_oe ? bus_out : (m_oe ? m_byte : ~last);
   epp_cycle_engine DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_byte_bus_in(bus), .port_byte_bus_out(bus_out),
      .port_byte_bus_oe(bus_oe), .transfer_direction_n(dir_n), .data_phase_strobe_n(ds_n),
      .address_phase_strobe_n(as_n), .init_n(init_n), .peripheral_hold_n(hold_n),
      .peripheral_interrupt(irq_in), .error_n(1'b1), .select(1'b1), .paper_end(1'b0),
      .parallel_irq(irq));
   epp_peripheral_model peer (.pclk(pclk), .data_phase_strobe_n(ds_n),
      .address_phase_strobe_n(as_n), .transfer_direction_n(dir_n), .bus_level(bus),
      .delay(delay), .stall(stall), .idle_high(idle_high), .read_byte(rbyte),
      .peripheral_hold_n(hold_n), .drive_oe(m_oe), .drive_byte(m_byte), .got_byte(got),
      .got_dir_n(dir_got), .got_addr(addr_got));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) last <= bus;
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [5:0] ad, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h000000, v};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 3000) chk(32'h0, 32'h1, "no answer");
   endtask
   initial begin
      #240000;
      miscompares++;
      summarize();
   end
   initial begin
      {presetn, psel, penable, pwrite, irq_in, stall, idle_high} = 7'h00;
      paddr = 6'h00;
      pwdata = 32'h00000000;
      delay = 5'h00;
      rbyte = 8'h00;
      repeat (2) @(posedge pclk);
      chk({28'h0, init_n, dir_n, ds_n, as_n}, 32'h7, "reset pins");
      presetn <= 1'b1;
      for (int m = 2; m < 4; m++) begin
         apb(1'b1, 6'h20, 8'(m));
         for (int i = 0; i < 6; i++) begin
            a = 6'((3 + i % 5) * 4);
            d = 8'($random(seed));
            rbyte <= 8'($random(seed));
            delay <= (i == 1) ? 5'h1F : 5'($random(seed));
            apb(1'b1, 6'h08, 8'h04);
            apb(1'b1, a, d);
            chk({24'h0, got}, {24'h0, d}, "written byte");
            chk({31'h0, addr_got}, {31'h0, a == 6'h0C}, "strobe kind");
            chk({31'h0, dir_got}, 32'h0, "write direction");
            apb(1'b1, 6'h08, (m == 3) ? 8'h24 : 8'h04);
            apb(1'b0, a, 8'h00);
            chk(rd, {24'h0, rbyte}, "read byte");
            chk({31'h0, dir_got}, 32'h1, "read direction");
         end
         stall <= 1'b1;
         apb(1'b0, 6'h10, 8'h00);
         chk(rd, {24'h0, epp_cycle_pkg::ABORT_READ_BYTE}, "abort");
         stall <= 1'b0;
         apb(1'b1, 6'h04, 8'h00);
         apb(1'b0, 6'h04, 8'h00);
         chk({31'h0, rd[0]}, 32'h1, "timeout flag");
         apb(1'b1, 6'h04, 8'h01);
         apb(1'b0, 6'h04, 8'h00);
         chk({31'h0, rd[0]}, 32'h0, "flag clear");
         $display("test cycles mode %0d done", m);
      end
      apb(1'b1, 6'h20, 8'h02);
      // Hold must be seen high at the take, so raise it a transfer early
      idle_high <= 1'b1;
      apb(1'b1, 6'h08, 8'h04);
      fork
         apb(1'b1, 6'h10, 8'hA5);
         begin
            repeat (30) @(posedge pclk);
            chk({30'h0, ds_n, dir_n}, 32'h3, "early strobe");
            idle_high <= 1'b0;
         end
      join
      chk({24'h0, got}, 32'hA5, "late write");
      apb(1'b1, 6'h08, 8'h24);
      apb(1'b1, 6'h10, 8'h5A);
      chk({30'h0, dir_got, err}, 32'h2, "write as read");
      apb(1'b1, 6'h08, 8'h05);
      apb(1'b0, 6'h10, 8'h00);
      chk({31'h0, dir_got}, 32'h0, "strobe override");
      $display("test overrides done");
      apb(1'b0, 6'h24, 8'h00);
      chk({31'h0, err}, 32'h1, "unmapped");
      apb(1'b1, 6'h08, 8'h14);
      irq_in <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "irq pass");
      apb(1'b1, 6'h08, 8'h04);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq mask");
      apb(1'b1, 6'h08, 8'h0B);
      repeat (2) @(posedge pclk);
      chk({28'h0, init_n, dir_n, ds_n, as_n}, 32'h0, "idle control");
      apb(1'b1, 6'h20, 8'h01);
      apb(1'b1, 6'h00, 8'h3C);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 32'h3C, "data register");
      chk({24'h0, bus}, 32'h3C, "data pins");
      irq_in <= 1'b0;
      repeat (8) @(posedge pclk);
      $display("test misc done");
      summarize();
   end
endmodule
